// ==== rtl/dtid_decoder.sv ====
// data-transfer instruction decoder and executor
`timescale 1ns/100ps
`default_nettype none
`include "dtid_params.svh"
module dtid_decoder (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	// instruction from fetch stage
	input  wire logic        insn_valid_i,
	input  wire logic [15:0] insn_i,
	input  wire logic [31:0] program_counter_i,
	input  wire logic        fetch_busy_i,
	output logic             insn_ready_o,
	// data memory port
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic [1:0]       mem_size_o,
	output logic [31:0]      mem_addr_o,
	output logic [31:0]      mem_wdata_o,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i,
	// status word and observation
	input  wire logic [31:0] status_word_i,
	output logic [31:0]      status_word_o,
	output logic             retire_o,
	output logic             illegal_o
);
	// ****************************************************************
	// decode helpers
	// ****************************************************************
	// size field of the low nibble, used for several opcode rows
	function automatic dtid_pkg::dtid_size_t size_of(input logic [1:0] s);
		unique case (s)
			2'h0:    size_of = dtid_pkg::dtid_sz_byte;
			2'h1:    size_of = dtid_pkg::dtid_sz_word;
			default: size_of = dtid_pkg::dtid_sz_long;
		endcase
	endfunction

	// byte step for the size: 1, 2 or 4
	function automatic logic [31:0] step_of(input dtid_pkg::dtid_size_t z);
		unique case (z)
			dtid_pkg::dtid_sz_byte: step_of = 32'h0000_0001;
			dtid_pkg::dtid_sz_word: step_of = 32'h0000_0002;
			default:                step_of = 32'h0000_0004;
		endcase
	endfunction

	// sign-extend loaded data to the register width
	function automatic logic [31:0] ext_of(input dtid_pkg::dtid_size_t z,
	                                       input logic [31:0] d);
		unique case (z)
			dtid_pkg::dtid_sz_byte: ext_of = {{24{d[7]}}, d[7:0]};
			dtid_pkg::dtid_sz_word: ext_of = {{16{d[15]}}, d[15:0]};
			default:                ext_of = d;
		endcase
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	dtid_pkg::dtid_state_t state_reg, state_next;
	dtid_pkg::dtid_kind_t  kind_reg, kind_next;
	dtid_pkg::dtid_size_t  size_reg, size_next;
	logic [3:0]  dst_reg, dst_next;
	logic [31:0] addr_reg, addr_next;
	logic        ld_pend_reg, ld_pend_next;
	logic [3:0]  ld_dst_reg, ld_dst_next;
	logic [15:0] held_reg, held_next;
	logic [31:0] pc_reg, pc_next;

	logic        rdy_next;
	logic        req_next;
	logic        we_next;
	logic [31:0] wdata_next;
	logic        retire_next;
	logic        illegal_next;

	// decoded fields of the incoming instruction
	logic [3:0]  op_w;
	logic [3:0]  rn_w;
	logic [3:0]  rm_w;
	logic [3:0]  sub_w;
	logic [7:0]  imm_w;
	dtid_pkg::dtid_kind_t dec_kind;
	dtid_pkg::dtid_size_t dec_size;
	logic        dec_reads_rn;
	logic        dec_reads_rm;

	// register file ports
	logic [31:0] rd_a_w;
	logic [31:0] rd_b_w;
	logic        wr0_en;
	logic [3:0]  wr0_idx;
	logic [31:0] wr0_data;
	logic        wr1_en;
	logic [3:0]  wr1_idx;
	logic [31:0] wr1_data;

	assign op_w  = held_reg[`DTID_OP_HI:`DTID_OP_LO];
	assign rn_w  = held_reg[`DTID_RN_HI:`DTID_RN_LO];
	assign rm_w  = held_reg[`DTID_RM_HI:`DTID_RM_LO];
	assign sub_w = held_reg[`DTID_SUB_HI:`DTID_SUB_LO];
	assign imm_w = held_reg[7:0];

	// classify the held instruction
	always_comb begin
		dec_kind     = dtid_pkg::dtid_k_none;
		dec_size     = dtid_pkg::dtid_sz_long;
		dec_reads_rn = 1'b0;
		dec_reads_rm = 1'b0;
		unique case (op_w)
			`DTID_OP_IMM: dec_kind = dtid_pkg::dtid_k_imm;
			`DTID_OP_PCW: begin
				dec_kind = dtid_pkg::dtid_k_pcrel;
				dec_size = dtid_pkg::dtid_sz_word;
			end
			`DTID_OP_PCL: dec_kind = dtid_pkg::dtid_k_pcrel;
			`DTID_OP_STORE: begin
				dec_size     = size_of(sub_w[1:0]);
				dec_reads_rn = 1'b1;
				dec_reads_rm = 1'b1;
				if (sub_w[3:2] == `DTID_SUB_PREDEC && sub_w[1:0] != 2'h3) begin
					dec_kind = dtid_pkg::dtid_k_predec;
				end else if (sub_w[3:2] == `DTID_SUB_IND && sub_w[1:0] != 2'h3) begin
					dec_kind = dtid_pkg::dtid_k_store;
				end
			end
			`DTID_OP_LOAD: begin
				dec_size     = size_of(sub_w[1:0]);
				dec_reads_rm = 1'b1;
				if (sub_w == `DTID_SUB_RR) begin
					dec_kind = dtid_pkg::dtid_k_rr;
				end else if (sub_w[3:2] == `DTID_SUB_IND && sub_w[1:0] != 2'h3) begin
					dec_kind = dtid_pkg::dtid_k_load;
				end
			end
			default: dec_kind = dtid_pkg::dtid_k_none;
		endcase
	end

	dtid_regfile u_regfile (
		.sys_clk_i   (sys_clk_i),
		.reset_n_i   (reset_n_i),
		.rd_a_idx_i  (held_next[`DTID_RN_HI:`DTID_RN_LO]),
		.rd_b_idx_i  (held_next[`DTID_RM_HI:`DTID_RM_LO]),
		.rd_a_data_o (rd_a_w),
		.rd_b_data_o (rd_b_w),
		.wr0_en_i    (wr0_en),
		.wr0_idx_i   (wr0_idx),
		.wr0_data_i  (wr0_data),
		.wr1_en_i    (wr1_en),
		.wr1_idx_i   (wr1_idx),
		.wr1_data_i  (wr1_data)
	);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	// idle: take insn (operands read one cycle later, from regfile regs);
	// stall: held insn executes; mem: wait for the data access ack
	always_comb begin
		state_next   = state_reg;
		kind_next    = kind_reg;
		size_next    = size_reg;
		dst_next     = dst_reg;
		addr_next    = addr_reg;
		ld_pend_next = 1'b0;
		ld_dst_next  = ld_dst_reg;
		held_next    = held_reg;
		pc_next      = pc_reg;
		rdy_next     = 1'b0;
		req_next     = mem_req_o;
		we_next      = mem_we_o;
		wdata_next   = mem_wdata_o;
		retire_next  = 1'b0;
		illegal_next = 1'b0;
		wr0_en       = 1'b0;
		wr0_idx      = rn_w;
		wr0_data     = 32'h0000_0000;
		wr1_en       = 1'b0;
		wr1_idx      = dst_reg;
		wr1_data     = ext_of(size_reg, mem_rdata_i);
		unique case (state_reg)
			dtid_pkg::dtid_st_idle: begin
				rdy_next = 1'b1;
				ld_pend_next = ld_pend_reg;
				if (insn_valid_i && insn_ready_o) begin
					held_next  = insn_i;
					pc_next    = program_counter_i;
					rdy_next   = 1'b0;
					state_next = dtid_pkg::dtid_st_stall;
				end
			end
			dtid_pkg::dtid_st_stall: begin
				kind_next = dec_kind;
				size_next = dec_size;
				dst_next  = rn_w;
				if (ld_pend_reg && ((dec_reads_rn && ld_dst_reg == rn_w)
				    || (dec_reads_rm && ld_dst_reg == rm_w))) begin
					// a source is the last load's target: stay in stall one more cycle and read again
					state_next = dtid_pkg::dtid_st_idle;
					rdy_next   = 1'b0;
				end else begin
					unique case (dec_kind)
						dtid_pkg::dtid_k_imm: begin
							wr0_en   = 1'b1;
							wr0_data = {{24{imm_w[7]}}, imm_w};
						end
						dtid_pkg::dtid_k_rr: begin
							wr0_en   = 1'b1;
							wr0_data = rd_b_w;
						end
						dtid_pkg::dtid_k_pcrel: begin
							addr_next = pc_reg + (step_of(dec_size)
							            * {24'h000000, imm_w});
							we_next   = 1'b0;
						end
						dtid_pkg::dtid_k_load: begin
							addr_next = rd_b_w;
							we_next   = 1'b0;
						end
						dtid_pkg::dtid_k_store: begin
							addr_next  = rd_a_w;
							we_next    = 1'b1;
							wdata_next = rd_b_w;
						end
						dtid_pkg::dtid_k_predec: begin
							addr_next  = rd_a_w - step_of(dec_size);
							wr0_en     = 1'b1;
							wr0_data   = rd_a_w - step_of(dec_size);
							we_next    = 1'b1;
							wdata_next = rd_b_w;
						end
						default: illegal_next = 1'b1;
					endcase
					if (dec_kind == dtid_pkg::dtid_k_none ||
					    dec_kind == dtid_pkg::dtid_k_imm ||
					    dec_kind == dtid_pkg::dtid_k_rr) begin
						retire_next = !illegal_next;
						rdy_next    = 1'b1;
						state_next  = dtid_pkg::dtid_st_idle;
					end else begin
						state_next = dtid_pkg::dtid_st_mem;
					end
				end
			end
			dtid_pkg::dtid_st_mem: begin
				// data access yields the bus to a running fetch
				req_next = !fetch_busy_i || mem_req_o;
				if (mem_req_o && mem_ack_i) begin
					req_next    = 1'b0;
					retire_next = 1'b1;
					rdy_next    = 1'b1;
					state_next  = dtid_pkg::dtid_st_idle;
					if (!mem_we_o) begin
						wr1_en       = 1'b1;
						ld_pend_next = 1'b1;
						ld_dst_next  = dst_reg;
					end
				end
			end
			default: state_next = dtid_pkg::dtid_st_idle;
		endcase
		// a hazard retry stays in stall holding the same instruction
		if (state_reg == dtid_pkg::dtid_st_stall && state_next ==
		    dtid_pkg::dtid_st_idle && !retire_next && !illegal_next) begin
			state_next   = dtid_pkg::dtid_st_stall;
			ld_pend_next = 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state_reg     <= dtid_pkg::dtid_st_idle;
			kind_reg      <= dtid_pkg::dtid_k_none;
			size_reg      <= dtid_pkg::dtid_sz_long;
			dst_reg       <= 4'h0;
			addr_reg      <= `DTID_RST_WORD;
			ld_pend_reg   <= 1'b0;
			ld_dst_reg    <= 4'h0;
			held_reg      <= 16'h0000;
			pc_reg        <= `DTID_RST_PC;
			insn_ready_o  <= 1'b0;
			mem_req_o     <= 1'b0;
			mem_we_o      <= 1'b0;
			mem_wdata_o   <= `DTID_RST_WORD;
			retire_o      <= 1'b0;
			illegal_o     <= 1'b0;
		end else begin
			state_reg     <= state_next;
			kind_reg      <= kind_next;
			size_reg      <= size_next;
			dst_reg       <= dst_next;
			addr_reg      <= addr_next;
			ld_pend_reg   <= ld_pend_next;
			ld_dst_reg    <= ld_dst_next;
			held_reg      <= held_next;
			pc_reg        <= pc_next;
			insn_ready_o  <= rdy_next;
			mem_req_o     <= req_next;
			mem_we_o      <= we_next;
			mem_wdata_o   <= wdata_next;
			retire_o      <= retire_next;
			illegal_o     <= illegal_next;
		end
	end

	// ****************************************************************
	// memory port and status word
	// ****************************************************************
	// address and size come straight from registers
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			mem_addr_o    <= `DTID_RST_WORD;
			mem_size_o    <= 2'h2;
			status_word_o <= `DTID_RST_WORD;
		end else begin
			mem_addr_o    <= addr_next;
			mem_size_o    <= size_next;
			status_word_o <= status_word_i;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/dtid_params.svh ====
// constants for the data-transfer instruction decoder
`ifndef DTID_PARAMS_SVH
`define DTID_PARAMS_SVH
// ****************************************************************
// instruction fields
// ****************************************************************
`define DTID_OP_HI      15
`define DTID_OP_LO      12
`define DTID_RN_HI      11
`define DTID_RN_LO      8
`define DTID_RM_HI      7
`define DTID_RM_LO      4
`define DTID_SUB_HI     3
`define DTID_SUB_LO     0
// ****************************************************************
// opcode nibbles and sub-codes
// ****************************************************************
`define DTID_OP_IMM     4'he
`define DTID_OP_PCW     4'h9
`define DTID_OP_PCL     4'hd
`define DTID_OP_STORE   4'h2
`define DTID_OP_LOAD    4'h6
`define DTID_SUB_RR     4'h3
`define DTID_SUB_PREDEC 2'h1
`define DTID_SUB_IND    2'h0
// ****************************************************************
// reset values and timing
// ****************************************************************
`define DTID_RST_WORD   32'h0000_0000
`define DTID_RST_PC     32'h0000_0000
`define DTID_MIN_CYCLES 1
`define DTID_TBIT       0
`endif

// ==== rtl/dtid_pkg.sv ====
// types shared by the data-transfer instruction decoder
package dtid_pkg;
	typedef enum logic [1:0] {
		dtid_sz_byte,
		dtid_sz_word,
		dtid_sz_long
	} dtid_size_t;

	typedef enum logic [2:0] {
		dtid_k_none,
		dtid_k_imm,
		dtid_k_pcrel,
		dtid_k_rr,
		dtid_k_store,
		dtid_k_predec,
		dtid_k_load
	} dtid_kind_t;

	typedef enum logic [1:0] {
		dtid_st_idle,
		dtid_st_mem,
		dtid_st_stall
	} dtid_state_t;
endpackage

// ==== rtl/dtid_regfile.sv ====
// sixteen general registers with two registered read ports
`timescale 1ns/100ps
`default_nettype none
`include "dtid_params.svh"
module dtid_regfile (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	// read ports
	input  wire logic [3:0]  rd_a_idx_i,
	input  wire logic [3:0]  rd_b_idx_i,
	output logic      [31:0] rd_a_data_o,
	output logic      [31:0] rd_b_data_o,
	// write ports, port 1 wins on equal index
	input  wire logic        wr0_en_i,
	input  wire logic [3:0]  wr0_idx_i,
	input  wire logic [31:0] wr0_data_i,
	input  wire logic        wr1_en_i,
	input  wire logic [3:0]  wr1_idx_i,
	input  wire logic [31:0] wr1_data_i
);
	logic [31:0] word_reg  [16];
	logic [31:0] word_next [16];
	logic [31:0] rd_a_next;
	logic [31:0] rd_b_next;

	// next values: direct four-bit index, 0000 is r0, 1111 is r15
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			word_next[i] = word_reg[i];
		end
		if (wr0_en_i) begin
			word_next[wr0_idx_i] = wr0_data_i;
		end
		if (wr1_en_i) begin
			word_next[wr1_idx_i] = wr1_data_i;
		end
		rd_a_next = word_reg[rd_a_idx_i];
		rd_b_next = word_reg[rd_b_idx_i];
	end

	// storage and registered read data
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 16; i++) begin
				word_reg[i] <= `DTID_RST_WORD;
			end
			rd_a_data_o <= `DTID_RST_WORD;
			rd_b_data_o <= `DTID_RST_WORD;
		end else begin
			for (int i = 0; i < 16; i++) begin
				word_reg[i] <= word_next[i];
			end
			rd_a_data_o <= rd_a_next;
			rd_b_data_o <= rd_b_next;
		end
	end
endmodule
`default_nettype wire

// ==== tb/dtid_decoder_props.sv ====
// port assertions for the data-transfer decoder
`timescale 1ns/100ps
`default_nettype none
module dtid_decoder_props (
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        reset_n_i,
	// fetch side
	input wire logic        insn_valid_i,
	input wire logic [15:0] insn_i,
	input wire logic [31:0] program_counter_i,
	input wire logic        fetch_busy_i,
	input wire logic        insn_ready_o,
	// data memory side
	input wire logic        mem_req_o,
	input wire logic        mem_we_o,
	input wire logic [1:0]  mem_size_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic        mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	// status and observation
	input wire logic [31:0] status_word_i,
	input wire logic [31:0] status_word_o,
	input wire logic        retire_o,
	input wire logic        illegal_o
);
	// ****************************************
	// timing relations at the ports
	// ****************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_take;
		insn_valid_i && insn_ready_o;
	endsequence
	sequence s_done;
		mem_req_o && mem_ack_i;
	endsequence
	// one instruction at a time: no back-to-back takes
	AST_TAKE_BLOCKS: assert property (s_take |=> !insn_ready_o)
		else $error("ready stayed high after a take");
	AST_IMM_RETIRE: assert property (
		(s_take ##0 insn_i[15:12] == 4'he) |-> ##[2:3] retire_o)
		else $error("immediate move did not retire in time");
	AST_PCW_WORD: assert property (
		(s_take ##0 insn_i[15:12] == 4'h9) |-> ##[2:12]
		($rose(mem_req_o) && mem_size_o == 2'h1 && !mem_we_o))
		else $error("pc-relative word load not issued as word read");
	AST_PCL_LONG: assert property (
		(s_take ##0 insn_i[15:12] == 4'hd) |-> ##[2:12]
		($rose(mem_req_o) && mem_size_o == 2'h2 && !mem_we_o))
		else $error("pc-relative long load not issued as long read");
	// the request and all that qualifies it hold until the ack edge
	AST_REQ_STEADY: assert property (
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
		&& $stable(mem_size_o) && $stable(mem_we_o)
		&& $stable(mem_wdata_o))
		else $error("request changed before ack");
	AST_ACK_RETIRE: assert property (s_done |=> retire_o && !mem_req_o)
		else $error("no retire one cycle after ack");
	// a data request never starts in a cycle the fetch owns the bus
	AST_FETCH_DEFER: assert property (
		$rose(mem_req_o) |-> !$past(fetch_busy_i))
		else $error("data request issued while fetch busy");
	AST_RETIRE_PULSE: assert property (
		retire_o |-> insn_ready_o ##1 !retire_o)
		else $error("retire not a single pulse with ready");
	AST_ILLEGAL_QUIET: assert property (
		illegal_o |-> !retire_o && !mem_req_o ##1 !illegal_o)
		else $error("illegal insn retired or accessed memory");
	// one settled cycle makes the copy meaningful; the check waits for two
	AST_STATUS_KEEP: assert property (
		$past(reset_n_i) && $past(reset_n_i, 2)
		|-> status_word_o == $past(status_word_i))
		else $error("status word altered");
endmodule
bind dtid_decoder dtid_decoder_props u_props (.sys_clk_i, .reset_n_i,
	.insn_valid_i, .insn_i, .program_counter_i, .fetch_busy_i,
	.insn_ready_o, .mem_req_o, .mem_we_o, .mem_size_o, .mem_addr_o,
	.mem_wdata_o, .mem_ack_i, .mem_rdata_i, .status_word_i,
	.status_word_o, .retire_o, .illegal_o);
`default_nettype wire

// ==== tb/dtid_mem_model.sv ====
// data memory partner answering the decoder's data requests
`timescale 1ns/100ps
`default_nettype none
module dtid_mem_model (
	// clock and request
	input wire logic        sys_clk_i,
	input wire logic        req_i,
	input wire logic [3:0]  wait_i,
	input wire logic [31:0] rd_val_i,
	// answer
	output logic            ack_o,
	output logic [31:0]     rdata_o
);
	// ****************************************
	// answer timing
	// ****************************************
	logic [3:0] cnt;
	initial begin
		cnt = 4'h0;
		ack_o = 1'b0;
		rdata_o = 32'h0;
	end
	// ack after wait_i held cycles; stale data is inverted each cycle
	// so a decoder that samples outside the ack cannot pass by luck
	always @(posedge sys_clk_i) begin
		cnt <= (req_i && !ack_o) ? cnt + 4'h1 : 4'h0;
		ack_o <= req_i && !ack_o && cnt >= wait_i;
		if (req_i && !ack_o && cnt >= wait_i) begin
			rdata_o <= rd_val_i;
		end else begin
			rdata_o <= ~rdata_o;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_data_transfer_insn_decoder.sv ====
// self-checking bench of the data-transfer decoder
`timescale 1ns/100ps
`default_nettype none
module tb_data_transfer_insn_decoder;
	// ****************************************
	// signals, clock and instances
	// ****************************************
	logic        sys_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        insn_valid_i = 1'b0;
	logic        fetch_busy_i = 1'b0;
	logic [15:0] insn_i = 16'h0000;
	logic [31:0] program_counter_i = 32'h0;
	logic [31:0] status_word_i = 32'h0;
	logic [31:0] rd_val = 32'h0;
	logic [3:0]  ack_wait = 4'h0;
	logic        insn_ready_o, mem_req_o, mem_we_o, mem_ack_i;
	logic        retire_o, illegal_o, g_we, g_ill;
	logic [1:0]  mem_size_o, g_size;
	logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, status_word_o;
	logic [31:0] g_addr, g_data;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          lat = 0;
	int          busy_len = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	// a moving status word, so a stale copy shows up
	always @(negedge sys_clk_i) status_word_i <= status_word_i + 32'h10003;
	dtid_decoder uut (.sys_clk_i, .reset_n_i, .insn_valid_i, .insn_i,
		.program_counter_i, .fetch_busy_i, .insn_ready_o, .mem_req_o,
		.mem_we_o, .mem_size_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i,
		.mem_rdata_i, .status_word_i, .status_word_o, .retire_o,
		.illegal_o);
	dtid_mem_model u_mem (.sys_clk_i, .req_i(mem_req_o),
		.wait_i(ack_wait), .rd_val_i(rd_val), .ack_o(mem_ack_i),
		.rdata_o(mem_rdata_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// offer one insn, note latency to first answer, follow to the end
	task automatic issue(input logic [15:0] insn, input logic [31:0] pc);
		int n;
		n = 0;
		while (insn_ready_o !== 1'b1 && n < 50) begin
			@(negedge sys_clk_i);
			n++;
		end
		insn_valid_i = 1'b1;
		insn_i = insn;
		program_counter_i = pc;
		fetch_busy_i = (busy_len > 0);
		@(negedge sys_clk_i);
		insn_valid_i = 1'b0;
		lat = 1;
		while (!(mem_req_o || retire_o || illegal_o) && lat < 40) begin
			if (lat == busy_len) fetch_busy_i = 1'b0;
			@(negedge sys_clk_i);
			lat++;
		end
		g_addr = mem_addr_o;
		g_data = mem_wdata_o;
		g_size = mem_size_o;
		g_we = mem_we_o;
		g_ill = illegal_o;
		n = 0;
		while (retire_o !== 1'b1 && illegal_o !== 1'b1 && n < 40) begin
			@(negedge sys_clk_i);
			n++;
		end
		if (n == 40) chk(32'h0, 32'h1);
		@(negedge sys_clk_i);
	endtask
	// store source_reg m at address in dest_reg n, compare the bus
	task automatic st(input logic [3:0] n, m, sub, input logic [31:0] ea, ed);
		issue({4'h2, n, m, sub}, 32'h0);
		chk({g_we, 29'h0, g_size}, {1'b1, 29'h0, sub[1:0]});
		chk(g_addr, ea);
		chk(g_data, ed);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_imm_rr();
		issue(16'he180, 32'h0);
		chk(32'(lat <= 3), 32'h1);
		issue(16'hef10, 32'h0);
		issue(16'he07f, 32'h0);
		issue(16'h6513, 32'h0);
		st(4'hf, 4'h0, 4'h2, 32'h10, 32'h7f);
		st(4'hf, 4'h5, 4'h2, 32'h10, 32'hffff_ff80);
		st(4'hf, 4'h5, 4'h1, 32'h10, 32'hffff_ff80);
	endtask
	task automatic t_pcrel();
		rd_val = 32'h5a5a_8123;
		issue(16'h9205, 32'h100);
		chk(g_addr, 32'h10a);
		rd_val = 32'h1234_5678;
		issue(16'hd303, 32'h200);
		chk(g_addr, 32'h20c);
		st(4'hf, 4'h2, 4'h2, 32'h10, 32'hffff_8123);
		st(4'hf, 4'h3, 4'h2, 32'h10, 32'h1234_5678);
	endtask
	// each load is read back at once, so the three read-back stores meet the hazard; the last store does not
	task automatic t_load();
		logic [31:0] vals [3] = '{32'h5a5a_5a80, 32'h5a5a_8001, 32'h89ab_cdef};
		logic [31:0] exps [3] = '{32'hffff_ff80, 32'hffff_8001, 32'h89ab_cdef};
		int hz;
		ack_wait = 4'h2;
		for (int i = 0; i < 3; i++) begin
			rd_val = vals[i];
			issue({8'h64, 4'hf, 2'h0, 2'(i)}, 32'h0);
			chk({30'h0, g_size}, 32'(i));
			st(4'hf, 4'h4, 4'h2, 32'h10, exps[i]);
			hz = lat;
		end
		st(4'hf, 4'h0, 4'h2, 32'h10, 32'h7f);
		chk(32'(hz), 32'(lat + 1));
		ack_wait = 4'h0;
	endtask
	task automatic t_predec();
		issue(16'he820, 32'h0);
		st(4'h8, 4'h0, 4'h4, 32'h1f, 32'h7f);
		st(4'h8, 4'h0, 4'h5, 32'h1d, 32'h7f);
		st(4'h8, 4'h0, 4'h6, 32'h19, 32'h7f);
		st(4'hf, 4'h8, 4'h2, 32'h10, 32'h19);
	endtask
	// fetch holds the bus for five cycles, then an unknown insn
	task automatic t_stall_bad();
		busy_len = 5;
		st(4'hf, 4'h0, 4'h0, 32'h10, 32'h7f);
		chk(32'(lat > 5), 32'h1);
		busy_len = 0;
		issue(16'h4015, 32'h0);
		chk({31'h0, g_ill}, 32'h1);
		st(4'hf, 4'h0, 4'h2, 32'h10, 32'h7f);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// main sequence after sixteen cycles of reset
	initial begin
		repeat (16) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		t_imm_rr();
		t_pcrel();
		t_load();
		t_predec();
		t_stall_bad();
		wrap_up();
	end
	// some 30 insns of under 20 cycles each; 10000 cycles is ample
	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
